// File: design/dstream_mmu_consts.svh
// How it works
// - data fault details land in fault status
// - fault or miss address lands in fault address
// - capture locks both; fault address read unlocks
// - status changes only unlocked or during the unlock read, on fault or miss
// - reset leaves both capture registers unlocked
// - status bits: write, violation, read/write fault
// - fault flags follow entry fault-on-read/write bits
// - status keeps source register and opcode fields
// - holding register read layout, zeros elsewhere
// - entry read loads holding, then holding read
// - zap clears all entries, resets replacement pointer
// - nonglobal invalidate clears entries without global bit
// - single invalidate clears entry matching given address
// - cache flush write flushes whole instruction cache
// - nonglobal flush drops blocks without global bit
// - machine check only when enabled, errors logged
// - soft-error acknowledge raises interrupt when enabled
// - stream buffer enable turns on stream buffer
// - first superpage maps kernel pattern addresses directly
// - second superpage passes bits 33:0 through
// - endian enable inverts physical address bit 2
`ifndef DSTREAM_MMU_CONSTS_SVH
`define DSTREAM_MMU_CONSTS_SVH

// register move indices
`define IDX_TAG 5'h00
`define IDX_PTE 5'h01
`define IDX_HOLD 5'h02
`define IDX_FSTAT 5'h03
`define IDX_FADDR 5'h04
`define IDX_ZAP 5'h05
`define IDX_NGINV 5'h06
`define IDX_SINV 5'h07
`define IDX_ICFL 5'h08
`define IDX_ICFLNG 5'h09
`define IDX_CTL 5'h0a

// control register bit positions
`define CTL_WBDIS 0
`define CTL_MCHK 1
`define CTL_CRD 2
`define CTL_SBUF 3
`define CTL_SP1 4
`define CTL_SP2 5
`define CTL_ENDIAN 6
`define CTL_RESET 7'h00

// entry write field positions (memory format)
`define PTE_FRAME_HI 52
`define PTE_FRAME_LO 32
`define PTE_WE_HI 15
`define PTE_WE_LO 12
`define PTE_RE_HI 11
`define PTE_RE_LO 8
`define PTE_GLOBAL 4
`define PTE_WRFAULT 2
`define PTE_RDFAULT 1

// translation constants
`define SP1_PATTERN 13'h1ffe
`define SP2_PATTERN 2'h2
`define MODE_KERNEL 2'h0
`define SOFT_ERROR_CODE 3'h5

`endif

// File: design/dstream_mmu_pkg.sv
package dstream_mmu_pkg;

  // captured fault status, top bit downward
  typedef struct packed {
    logic [5:0] opcode;
    logic [4:0] source_register_field;
    logic write_fault_flag;
    logic read_fault_flag;
    logic access_violation_flag;
    logic write_flag;
  } fault_status_t;

  // one translation entry payload
  typedef struct packed {
    logic global_mapping_bit;
    logic [20:0] page_frame_number;
    logic [3:0] read_en;
    logic [3:0] write_en;
    logic fault_on_write;
    logic fault_on_read;
  } pte_t;

  // load/store unit control bits
  typedef struct packed {
    logic endian_invert_enable;
    logic second_superpage_enable;
    logic first_superpage_enable;
    logic stream_buffer_enable;
    logic corrected_read_interrupt_enable;
    logic machine_check_enable;
    logic write_buffer_unload_disable;
  } ctl_t;

  // data-stream reference from the pipeline
  typedef struct packed {
    logic valid;
    logic [42:0] va;
    logic [1:0] mode;
    logic is_write;
    logic [5:0] opcode;
    logic [4:0] source_register_field;
  } ds_req_t;

endpackage : dstream_mmu_pkg

// File: design/dstream_mmu_control.sv
`timescale 1ns/1ps
`include "dstream_mmu_consts.svh"

module dstream_mmu_control
  import dstream_mmu_pkg::*;
#(
  parameter int ENTRIES = 32
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // privileged register moves
  input wire logic i_wr_valid,
  input wire logic [4:0] i_wr_index,
  input wire logic [63:0] i_wr_data,
  input wire logic i_rd_valid,
  input wire logic [4:0] i_rd_index,
  output logic o_rd_valid,
  output logic [63:0] o_rd_data,
  // data-stream translation
  input wire ds_req_t i_ds,
  output logic o_xlate_valid,
  output logic [33:0] o_xlate_pa,
  output logic o_xlate_miss,
  output logic o_xlate_fault,
  // write buffer
  input wire logic i_wb_unload_req,
  output logic o_wb_unload_grant,
  // error reporting
  input wire logic i_uncorr_error,
  output logic o_machine_check,
  output logic o_err_regs_update,
  input wire logic i_bus_done,
  input wire logic [2:0] i_ack_code,
  output logic o_crd_irq,
  // instruction cache
  output logic o_stream_buffer_en,
  output logic o_icache_flush,
  output logic o_icache_flush_nonglobal
);

  localparam int PTR_W = $clog2(ENTRIES);

  // first set bit of a match vector
  function automatic logic [PTR_W-1:0] first_hit(input logic [ENTRIES-1:0] v);
    logic [PTR_W-1:0] idx;
    idx = '0;
    for (int k = ENTRIES - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = PTR_W'(k);
      end
    end
    return idx;
  endfunction : first_hit

  // state
  ctl_t ctl;
  logic [29:0] tag_reg;
  pte_t entry [ENTRIES];
  logic [29:0] etag [ENTRIES];
  logic [ENTRIES-1:0] valid;
  logic [ENTRIES-1:0] next_valid;
  logic [PTR_W-1:0] ptr;
  pte_t hold;
  fault_status_t fstat;
  logic [42:0] faddr;
  logic locked;

  // register move decode
  wire wr_tag = i_wr_valid && (i_wr_index == `IDX_TAG);
  wire wr_pte = i_wr_valid && (i_wr_index == `IDX_PTE);
  wire wr_zap = i_wr_valid && (i_wr_index == `IDX_ZAP);
  wire wr_nginv = i_wr_valid && (i_wr_index == `IDX_NGINV);
  wire wr_sinv = i_wr_valid && (i_wr_index == `IDX_SINV);
  wire wr_icfl = i_wr_valid && (i_wr_index == `IDX_ICFL);
  wire wr_icflng = i_wr_valid && (i_wr_index == `IDX_ICFLNG);
  wire wr_ctl = i_wr_valid && (i_wr_index == `IDX_CTL);
  wire rd_pte = i_rd_valid && (i_rd_index == `IDX_PTE);
  wire rd_faddr = i_rd_valid && (i_rd_index == `IDX_FADDR);

  // entry payload from memory-format write data
  pte_t new_pte;
  assign new_pte.global_mapping_bit = i_wr_data[`PTE_GLOBAL];
  assign new_pte.page_frame_number = i_wr_data[`PTE_FRAME_HI:`PTE_FRAME_LO];
  assign new_pte.read_en = i_wr_data[`PTE_RE_HI:`PTE_RE_LO];
  assign new_pte.write_en = i_wr_data[`PTE_WE_HI:`PTE_WE_LO];
  assign new_pte.fault_on_write = i_wr_data[`PTE_WRFAULT];
  assign new_pte.fault_on_read = i_wr_data[`PTE_RDFAULT];

  // per-entry match vectors and storage
  logic [ENTRIES-1:0] hit_vec;
  logic [ENTRIES-1:0] sinv_vec;
  logic [ENTRIES-1:0] ng_vec;
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : gen_entry
      assign hit_vec[g] = valid[g] && (etag[g] == i_ds.va[42:13]);
      assign sinv_vec[g] = valid[g] && (etag[g] == i_wr_data[42:13]);
      assign ng_vec[g] = !entry[g].global_mapping_bit;
      // entry written at the replacement pointer with the staged tag
      always_ff @(posedge i_core_clk) begin
        if (wr_pte && (ptr == PTR_W'(g))) begin
          entry[g] <= new_pte;
          etag[g] <= tag_reg;
        end
      end
    end
  endgenerate

  // translation lookup
  wire [PTR_W-1:0] hit_idx = first_hit(hit_vec);
  pte_t hit_pte;
  assign hit_pte = entry[hit_idx];
  wire kernel = (i_ds.mode == `MODE_KERNEL);
  wire sp1 = ctl.first_superpage_enable && (i_ds.va[42:30] == `SP1_PATTERN);
  wire sp2 = ctl.second_superpage_enable && (i_ds.va[42:41] == `SP2_PATTERN);
  wire superpage = sp1 || sp2;
  wire tb_hit = |hit_vec;
  wire mapped = i_ds.valid && !superpage && tb_hit;
  wire miss = i_ds.valid && !superpage && !tb_hit;
  wire perm_ok = i_ds.is_write ? hit_pte.write_en[i_ds.mode] : hit_pte.read_en[i_ds.mode];
  wire viol = i_ds.valid && (superpage ? !kernel : (tb_hit && !perm_ok));
  wire rd_flt = mapped && !i_ds.is_write && hit_pte.fault_on_read;
  wire wr_flt = mapped && i_ds.is_write && hit_pte.fault_on_write;
  wire fault = viol || rd_flt || wr_flt;

  // physical address selection
  wire [33:0] sp1_pa = {4'h0, i_ds.va[29:0]};
  wire [33:0] sp2_pa = i_ds.va[33:0];
  wire [33:0] tb_pa = {hit_pte.page_frame_number, i_ds.va[12:0]};
  wire [33:0] raw_pa = sp1 ? sp1_pa : (sp2 ? sp2_pa : tb_pa);
  wire [33:0] next_pa = {raw_pa[33:3], raw_pa[2] ^ ctl.endian_invert_enable, raw_pa[1:0]};

  // capture allowed while unlocked; a new fault beats the unlock read
  wire capture = (miss || fault) && (!locked || rd_faddr);
  fault_status_t next_fstat;
  assign next_fstat.opcode = i_ds.opcode;
  assign next_fstat.source_register_field = i_ds.source_register_field;
  assign next_fstat.write_fault_flag = wr_flt;
  assign next_fstat.read_fault_flag = rd_flt;
  assign next_fstat.access_violation_flag = viol;
  assign next_fstat.write_flag = i_ds.is_write;

  // entry valid bits after invalidation writes
  always_comb begin
    next_valid = valid;
    if (wr_pte) begin
      next_valid[ptr] = 1'b1;
    end
    if (wr_sinv) begin
      next_valid = valid & ~sinv_vec;
    end
    if (wr_nginv) begin
      next_valid = valid & ~ng_vec;
    end
    if (wr_zap) begin
      next_valid = '0;
    end
  end

  // holding register read format
  wire [63:0] hold_rd = {29'h0, hold.global_mapping_bit, hold.page_frame_number, hold.read_en,
                         hold.write_en, hold.fault_on_write, hold.fault_on_read, 3'h0};

  // read data select; write-only and pseudo registers read zero
  wire [63:0] next_rd_data = (i_rd_index == `IDX_HOLD) ? hold_rd :
                             (i_rd_index == `IDX_FSTAT) ? {49'h0, fstat} :
                             (i_rd_index == `IDX_FADDR) ? {21'h0, faddr} : 64'h0;

  // control bits from a write
  ctl_t next_ctl;
  assign next_ctl.endian_invert_enable = i_wr_data[`CTL_ENDIAN];
  assign next_ctl.second_superpage_enable = i_wr_data[`CTL_SP2];
  assign next_ctl.first_superpage_enable = i_wr_data[`CTL_SP1];
  assign next_ctl.stream_buffer_enable = i_wr_data[`CTL_SBUF];
  assign next_ctl.corrected_read_interrupt_enable = i_wr_data[`CTL_CRD];
  assign next_ctl.machine_check_enable = i_wr_data[`CTL_MCHK];
  assign next_ctl.write_buffer_unload_disable = i_wr_data[`CTL_WBDIS];

  // control register, write-only, cleared by reset
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctl <= ctl_t'(`CTL_RESET);
    end else if (wr_ctl) begin
      ctl <= next_ctl;
    end
  end

  // tag staged for the next entry write
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      tag_reg <= 30'h0;
    end else if (wr_tag) begin
      tag_reg <= i_wr_data[42:13];
    end
  end

  // entry valid bits
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      valid <= '0;
    end else begin
      valid <= next_valid;
    end
  end

  // replacement pointer steps on every entry move; zap rewinds it
  wire ptr_step = wr_pte || rd_pte;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ptr <= '0;
    end else if (wr_zap) begin
      ptr <= '0;
    end else if (ptr_step) begin
      ptr <= ptr + PTR_W'(1);
    end
  end

  // entry read moves the pointed entry into the holding register
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      hold <= '0;
    end else if (rd_pte) begin
      hold <= entry[ptr];
    end
  end

  // fault capture and lock
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      fstat <= '0;
      faddr <= 43'h0;
      locked <= 1'b0;
    end else if (capture) begin
      fstat <= next_fstat;
      faddr <= i_ds.va;
      locked <= 1'b1;
    end else if (rd_faddr) begin
      locked <= 1'b0;
    end
  end

  // read answer strobe, one cycle after the request
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_valid;
    end
  end

  // read answer data, zero between answers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rd_data <= 64'h0;
    end else begin
      o_rd_data <= i_rd_valid ? next_rd_data : 64'h0;
    end
  end

  // registered translation address
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_xlate_valid <= 1'b0;
      o_xlate_pa <= 34'h0;
    end else begin
      o_xlate_valid <= i_ds.valid;
      o_xlate_pa <= i_ds.valid ? next_pa : 34'h0;
    end
  end

  // registered translation status
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_xlate_miss <= 1'b0;
      o_xlate_fault <= 1'b0;
    end else begin
      o_xlate_miss <= miss;
      o_xlate_fault <= fault;
    end
  end

  // next values of the side controls
  wire next_grant = i_wb_unload_req && !ctl.write_buffer_unload_disable;
  wire next_mchk = i_uncorr_error && ctl.machine_check_enable;
  wire soft_error_done = i_bus_done && (i_ack_code == `SOFT_ERROR_CODE);
  wire next_crd = soft_error_done && ctl.corrected_read_interrupt_enable;

  // write buffer unload grant, held off while disabled
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_wb_unload_grant <= 1'b0;
    end else begin
      o_wb_unload_grant <= next_grant;
    end
  end

  // machine check pulse, only when enabled
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_machine_check <= 1'b0;
    end else begin
      o_machine_check <= next_mchk;
    end
  end

  // error registers update on every uncorrectable error
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_err_regs_update <= 1'b0;
    end else begin
      o_err_regs_update <= i_uncorr_error;
    end
  end

  // corrected-read interrupt request
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_crd_irq <= 1'b0;
    end else begin
      o_crd_irq <= next_crd;
    end
  end

  // stream buffer enable level
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_stream_buffer_en <= 1'b0;
    end else begin
      o_stream_buffer_en <= ctl.stream_buffer_enable;
    end
  end

  // whole instruction cache flush pulse
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_icache_flush <= 1'b0;
    end else begin
      o_icache_flush <= wr_icfl;
    end
  end

  // non-global instruction cache flush pulse
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_icache_flush_nonglobal <= 1'b0;
    end else begin
      o_icache_flush_nonglobal <= wr_icflng;
    end
  end

endmodule : dstream_mmu_control

// File: tb/mmu_checker.sv
`timescale 1ns/1ps
module mmu_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // register reads
  input wire logic i_rd_valid,
  input wire logic [4:0] i_rd_index,
  input wire logic o_rd_valid,
  input wire logic [63:0] o_rd_data,
  // side controls
  input wire logic i_wb_unload_req,
  input wire logic o_wb_unload_grant,
  input wire logic i_uncorr_error,
  input wire logic o_machine_check,
  input wire logic o_err_regs_update,
  input wire logic i_bus_done,
  input wire logic [2:0] i_ack_code,
  input wire logic o_crd_irq
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  // read answers and layouts
  rd_answer_a: assert property (i_rd_valid |=> o_rd_valid)
    else $error("read unanswered");
  stat_zero_a: assert property (i_rd_valid && i_rd_index == 5'h03 |=> o_rd_data[63:15] == 49'h0)
    else $error("status upper bits set");
  hold_zero_a: assert property (i_rd_valid && i_rd_index == 5'h02 |-> ##1
    (o_rd_data[63:35] == 29'h0) && (o_rd_data[2:0] == 3'h0)) else $error("holding zero bits set");
  ctl_wo_a: assert property (i_rd_valid && i_rd_index == 5'h0a |=> o_rd_data == 64'h0)
    else $error("control readable");
  // side effects of control bits
  grant_cause_a: assert property (o_wb_unload_grant |-> $past(i_wb_unload_req))
    else $error("grant without request");
  mchk_cause_a: assert property (o_machine_check |-> $past(i_uncorr_error))
    else $error("stray machine check");
  err_log_a: assert property (i_uncorr_error |-> ##1 o_err_regs_update)
    else $error("error not logged");
  crd_cause_a: assert property (o_crd_irq |-> $past(i_bus_done) && $past(i_ack_code) == 3'h5)
    else $error("stray soft error irq");
endmodule : mmu_checker

bind dstream_mmu_control mmu_checker u_mmu_checker (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_rd_valid(i_rd_valid), .i_rd_index(i_rd_index),
  .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_wb_unload_req(i_wb_unload_req),
  .o_wb_unload_grant(o_wb_unload_grant), .i_uncorr_error(i_uncorr_error), .o_machine_check(o_machine_check),
  .o_err_regs_update(o_err_regs_update), .i_bus_done(i_bus_done), .i_ack_code(i_ack_code), .o_crd_irq(o_crd_irq)
);

// File: tb/pipe_model.sv
`timescale 1ns/1ps
module pipe_model
  import dstream_mmu_pkg::*;
(
  // clock
  input wire logic i_core_clk,
  // requests
  output logic o_wr_valid,
  output logic [4:0] o_wr_index,
  output logic [63:0] o_wr_data,
  output logic o_rd_valid,
  output logic [4:0] o_rd_index,
  output ds_req_t o_ds,
  // answers
  input wire logic i_rd_valid,
  input wire logic [63:0] i_rd_data,
  input wire logic i_xlate_valid,
  input wire logic [33:0] i_xlate_pa,
  input wire logic i_xlate_miss,
  input wire logic i_xlate_fault
);
  // idle at time zero
  initial begin
    o_wr_valid = 1'b0;
    o_wr_index = 5'h00;
    o_wr_data = 64'h0;
    o_rd_valid = 1'b0;
    o_rd_index = 5'h00;
    o_ds = '0;
  end
  // one write move, data inverted once released
  task automatic wr(input logic [4:0] idx, input logic [63:0] d);
    @(posedge i_core_clk);
    #1;
    o_wr_valid = 1'b1;
    o_wr_index = idx;
    o_wr_data = d;
    @(posedge i_core_clk);
    #1;
    o_wr_valid = 1'b0;
    o_wr_data = ~d;
  endtask : wr
  // one read move, answer taken one edge later
  task automatic rd(input logic [4:0] idx, output logic [63:0] d);
    @(posedge i_core_clk);
    #1;
    o_rd_valid = 1'b1;
    o_rd_index = idx;
    @(posedge i_core_clk);
    #1;
    o_rd_valid = 1'b0;
    d = i_rd_valid ? i_rd_data : 64'hx;
  endtask : rd
  // entry read: load holding, then fetch it
  task automatic entry_rd(output logic [63:0] d);
    rd(5'h01, d);
    rd(5'h02, d);
  endtask : entry_rd
  // one data-stream reference, r = miss, fault, pa
  task automatic ds(input logic [42:0] va, input logic [1:0] md, input logic w, output logic [35:0] r);
    @(posedge i_core_clk);
    #1;
    o_ds = '{1'b1, va, md, w, 6'h2a, 5'h13};
    @(posedge i_core_clk);
    #1;
    o_ds = ds_req_t'(~o_ds);
    r = i_xlate_valid ? {i_xlate_miss, i_xlate_fault, i_xlate_pa} : 36'hx;
  endtask : ds
endmodule : pipe_model

// File: tb/dstream_mmu_control_tb.sv
`timescale 1ns/1ps
module dstream_mmu_control_tb;
  import dstream_mmu_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic wr_v, rd_v, rd_ok, xv, xm, xf, gnt, mchk, errup, crd, sbuf, fl, fln;
  logic [4:0] wr_i, rd_i;
  logic [63:0] wr_d, rd_d;
  logic [33:0] xpa;
  ds_req_t ds;
  logic wb_req = 1'b0;
  logic uerr = 1'b0;
  logic bdone = 1'b0;
  logic [2:0] ack = 3'h0;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  dstream_mmu_control u_dstream_mmu_control (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_wr_valid(wr_v), .i_wr_index(wr_i), .i_wr_data(wr_d),
    .i_rd_valid(rd_v), .i_rd_index(rd_i), .o_rd_valid(rd_ok), .o_rd_data(rd_d), .i_ds(ds),
    .o_xlate_valid(xv), .o_xlate_pa(xpa), .o_xlate_miss(xm), .o_xlate_fault(xf),
    .i_wb_unload_req(wb_req), .o_wb_unload_grant(gnt), .i_uncorr_error(uerr), .o_machine_check(mchk),
    .o_err_regs_update(errup), .i_bus_done(bdone), .i_ack_code(ack), .o_crd_irq(crd),
    .o_stream_buffer_en(sbuf), .o_icache_flush(fl), .o_icache_flush_nonglobal(fln)
  );
  pipe_model u_pipe_model (
    .i_core_clk(i_core_clk), .o_wr_valid(wr_v), .o_wr_index(wr_i), .o_wr_data(wr_d), .o_rd_valid(rd_v),
    .o_rd_index(rd_i), .o_ds(ds), .i_rd_valid(rd_ok), .i_rd_data(rd_d), .i_xlate_valid(xv),
    .i_xlate_pa(xpa), .i_xlate_miss(xm), .i_xlate_fault(xf)
  );

  // clock and hang guard
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic miss(input logic [29:0] t, input logic e);
    logic [35:0] r;
    u_pipe_model.ds({t, 13'h0}, 2'h0, 1'b0, r);
    chk(64'(r[35]), 64'(e), "miss");
  endtask : miss

  task automatic t_reset();
    logic [63:0] d;
    for (int k = 2; k < 5; k++) begin
      u_pipe_model.rd(5'(k), d);
      chk(d, 64'h0, "reset read");
    end
    u_pipe_model.rd(5'h0a, d);
    chk(d, 64'h0, "control read");
    chk(64'(sbuf), 64'h0, "sbuf reset");
    $display("reset test done");
  endtask : t_reset

  task automatic t_entries();
    logic [63:0] d;
    for (int i = 0; i < 32; i++) begin
      u_pipe_model.wr(5'h00, {21'h0, 30'(i + 1), 13'h0});
      u_pipe_model.wr(5'h01, {11'h0, 21'(i + 7), 16'h0, 8'hff, 3'h0, ~i[0], 1'b0, i == 1, 2'h0});
    end
    u_pipe_model.entry_rd(d);
    chk(d, {29'h0, 1'b1, 21'd7, 8'hff, 5'h0}, "holding");
    $display("entry test done");
  endtask : t_entries

  task automatic t_faults();
    logic [35:0] r;
    logic [63:0] d;
    u_pipe_model.ds({13'h0, 30'd2, 13'h8}, 2'h0, 1'b1, r);
    chk(64'(r[35:34]), 64'h1, "write fault");
    u_pipe_model.ds({13'h0, 30'd99, 13'h0}, 2'h0, 1'b0, r);
    u_pipe_model.rd(5'h03, d);
    chk(d, {49'h0, 6'h2a, 5'h13, 4'h9}, "status");
    u_pipe_model.rd(5'h04, d);
    chk(d, {21'h0, 30'd2, 13'h8}, "address");
    u_pipe_model.ds({13'h0, 30'd99, 13'h0}, 2'h0, 1'b0, r);
    u_pipe_model.rd(5'h04, d);
    chk(d, {21'h0, 30'd99, 13'h0}, "unlocked address");
    u_pipe_model.rd(5'h03, d);
    chk(d, {49'h0, 6'h2a, 5'h13, 4'h0}, "miss status");
    $display("fault test done");
  endtask : t_faults

  task automatic t_inval();
    miss(30'd4, 1'b0);
    u_pipe_model.wr(5'h07, {21'h0, 30'd4, 13'h0});
    miss(30'd4, 1'b1);
    u_pipe_model.wr(5'h06, 64'h0);
    miss(30'd5, 1'b0);
    miss(30'd6, 1'b1);
    u_pipe_model.wr(5'h05, 64'h0);
    miss(30'd5, 1'b1);
    $display("invalidate test done");
  endtask : t_inval

  task automatic t_ctl(input logic [6:0] c);
    logic [35:0] r;
    u_pipe_model.wr(5'h0a, {57'h0, c});
    @(posedge i_core_clk);
    #1;
    chk(64'(sbuf), 64'(c[3]), "sbuf");
    u_pipe_model.ds({13'h1ffe, 30'h1}, 2'h0, 1'b0, r);
    chk(64'(r[35]), 64'(!c[4]), "sp1 miss");
    if (c[4]) chk(64'(r[33:0]), {61'h0, c[6], 2'h1}, "sp1 pa");
    u_pipe_model.ds({13'h1ffe, 30'h1}, 2'h3, 1'b0, r);
    chk(64'(r[35:34]), c[4] ? 64'h1 : 64'h2, "sp1 user");
    u_pipe_model.ds({2'h2, 7'h55, 34'h1_2345_6000}, 2'h0, 1'b0, r);
    chk(64'(r[35]), 64'(!c[5]), "sp2 miss");
    if (c[5]) chk(64'(r[33:0]), 64'h1_2345_6000 ^ {61'h0, c[6], 2'h0}, "sp2 pa");
    @(posedge i_core_clk);
    #1;
    {wb_req, uerr, bdone, ack} = 6'h3d;
    @(posedge i_core_clk);
    #1;
    {wb_req, uerr, bdone, ack} = 6'h02;
    chk(64'(gnt), 64'(!c[0]), "grant");
    chk(64'(mchk), 64'(c[1]), "mchk");
    chk(64'(errup), 64'h1, "err log");
    chk(64'(crd), 64'(c[2]), "crd irq");
    $display("control test done");
  endtask : t_ctl

  task automatic t_flush();
    u_pipe_model.wr(5'h08, 64'h0);
    chk(64'(fl), 64'h1, "flush");
    u_pipe_model.wr(5'h09, 64'h0);
    chk(64'(fln), 64'h1, "ng flush");
    $display("flush test done");
  endtask : t_flush

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    repeat (2) @(posedge i_core_clk);
    #1;
    i_srst = 1'b0;
    t_reset();
    t_entries();
    t_faults();
    t_inval();
    t_ctl(7'h7f);
    t_ctl(7'h00);
    t_flush();
    stop_test();
  end
endmodule : dstream_mmu_control_tb
